// ### bench/ptc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module ptc_host_model (
  // clock
  input wire logic sys_clk,
  // serial pins
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso_ff
);
  // sclk rests low between frames
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // ----------------------------------------
  // frame tasks
  // ----------------------------------------
  // two sys_clk per phase, half the fastest rate the port still resolves
  task automatic frame(input logic [7:0] addr, input logic [23:0] data, output logic [23:0] rdata);
    logic [31:0] word;
    word = {addr, data};
    rdata = 24'h00_0000;
    @(posedge sys_clk);
    spi_cs_n <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      spi_sclk <= 1'b0;
      spi_mosi <= word[i];
      repeat (2) @(posedge sys_clk);
      spi_sclk <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rdata = {rdata[22:0], spi_miso_ff};
    end
    spi_sclk <= 1'b0;
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic write_reg(input logic [7:0] addr, input logic [23:0] data);
    logic [23:0] word;
    logic [23:0] unused;
    word = data;
    if (addr inside {8'h1b, 8'h1c, 8'h1d})
      word[23:16] = 8'h00;
    if (addr == 8'h1e)
      word = {12'h000, word[11:8], 8'h02};
    if (addr inside {8'h1f, 8'h20})
      word = 24'h00_0000;
    frame({1'b0, addr[6:0]}, word, unused);
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [23:0] data);
    frame({1'b1, addr[6:0]}, 24'h00_0000, data);
  endtask
endmodule

`default_nettype wire

// ### bench/ptc_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none

module ptc_regs_checker #(
  parameter int COUNT_W = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // serial port
  input wire logic spi_cs_n,
  input wire logic spi_miso_ff,
  // alarm pins
  input wire logic photodiode_alarm_pin_ff,
  input wire logic photodiode_alarm_oe_ff,
  input wire logic emitter_alarm_pin_ff,
  input wire logic emitter_alarm_oe_ff,
  // timebase
  input wire logic timer_tick_ff,
  input wire logic period_start_ff,
  input wire logic [COUNT_W-1:0] timer_count_ff
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_pd_pin_quiet: assert property (!photodiode_alarm_oe_ff |-> !photodiode_alarm_pin_ff)
    else $error("photodiode alarm pin high while undriven");
  a_em_pin_quiet: assert property (!emitter_alarm_oe_ff |-> !emitter_alarm_pin_ff)
    else $error("emitter alarm pin high while undriven");
  a_oe_pair_match: assert property (photodiode_alarm_oe_ff == emitter_alarm_oe_ff)
    else $error("alarm pin enables disagree");
  a_miso_idle_low: assert property (spi_cs_n && $past(spi_cs_n) |-> !spi_miso_ff)
    else $error("serial out active outside a frame");
  a_count_step_one: assert property ($changed(timer_count_ff) && timer_count_ff != '0
    |-> timer_count_ff == $past(timer_count_ff) + 1'b1)
    else $error("period counter skipped a value");
  a_tick_single_pulse: assert property (timer_tick_ff |=> !timer_tick_ff)
    else $error("timer tick faster than the timing clock");
  a_wrap_at_zero: assert property (period_start_ff |-> timer_count_ff == '0)
    else $error("period start without counter at zero");
  a_wrap_single_pulse: assert property (period_start_ff |=> !period_start_ff)
    else $error("period start longer than one cycle");
endmodule

bind ptc_regs_top ptc_regs_checker #(.COUNT_W(COUNT_W)) i_chk (.sys_clk(sys_clk), .rst(rst),
  .spi_cs_n(spi_cs_n), .spi_miso_ff(spi_miso_ff), .photodiode_alarm_pin_ff(photodiode_alarm_pin_ff),
  .photodiode_alarm_oe_ff(photodiode_alarm_oe_ff), .emitter_alarm_pin_ff(emitter_alarm_pin_ff),
  .emitter_alarm_oe_ff(emitter_alarm_oe_ff), .timer_tick_ff(timer_tick_ff),
  .period_start_ff(period_start_ff), .timer_count_ff(timer_count_ff));

`default_nettype wire

// ### bench/test_pulse_timing_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptc_cfg.svh"

module test_pulse_timing_control_regs;
  logic sys_clk, rst, spi_miso_ff, pd_pin, pd_oe, em_pin, em_oe, tick, pstart, win;
  logic [8:0] leds;
  logic [15:0] count;
  wire spi_sclk, spi_cs_n, spi_mosi;
  int mismatches;
  int n_compared;

  ptc_host_model i_host (.sys_clk(sys_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso_ff(spi_miso_ff));

  ptc_regs_top i_dut (.sys_clk(sys_clk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso_ff(spi_miso_ff), .led2_sample(leds[0]), .led1_sample(leds[1]),
    .led2_pulse(leds[2]), .led1_pulse(leds[3]), .led1_sample_pulse(leds[4]), .led2_convert(leds[5]),
    .led1_convert(leds[6]), .led2_ambient(leds[7]), .led1_ambient(leds[8]),
    .photodiode_alarm_pin_ff(pd_pin), .photodiode_alarm_oe_ff(pd_oe), .emitter_alarm_pin_ff(em_pin),
    .emitter_alarm_oe_ff(em_oe), .timer_tick_ff(tick), .period_start_ff(pstart),
    .timer_count_ff(count), .adc_clear3_window_ff(win));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // counts ticks, wraps and window cycles over n settled cycles
  task automatic sample(input int n, output logic [23:0] t, output logic [23:0] w, output logic [23:0] v);
    t = 24'h00_0000;
    w = 24'h00_0000;
    v = 24'h00_0000;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      t = t + tick;
      w = w + pstart;
      v = v + win;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [23:0] got;
    for (int a = 'h1b; a <= 'h20; a++) begin
      i_host.read_reg(8'(a), got);
      chk(got, 24'h00_0000);
    end
    $display("test reset values done");
  endtask

  task automatic t_regs();
    logic [23:0] got;
    logic [7:0] ad [6] = '{8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h25};
    logic [23:0] wv [6] = '{24'h00_a5c3, 24'h00_ffff, 24'h00_0001, 24'h00_0a00, 24'h00_0000, 24'h00_1234};
    logic [23:0] ev [6] = '{24'h00_a5c3, 24'h00_ffff, 24'h00_0001, 24'h00_0a00, 24'h00_0000, 24'h00_0000};
    for (int i = 0; i < 6; i++)
      i_host.write_reg(ad[i], wv[i]);
    for (int i = 0; i < 6; i++) begin
      i_host.read_reg(ad[i], got);
      chk(got, ev[i]);
    end
    $display("test register access done");
  endtask

  task automatic t_alarm();
    int pd_idx[5] = '{0, 2, 0, 5, 7};
    int em_idx[5] = '{1, 3, 4, 6, 8};
    for (int c = 0; c < 8; c++) begin
      i_host.write_reg(`PTC_ADDR_CONTROL, {12'h000, c[2:0], 9'h000});
      for (int s = 0; s < 2; s++) begin
        @(posedge sys_clk);
        leds <= (c < 5) ? 9'h001 << (s ? em_idx[c] : pd_idx[c]) : 9'h1ff;
        repeat (2) @(posedge sys_clk);
        #1;
        chk({22'h00_0000, pd_oe, em_oe}, (c < 5) ? 24'h00_0003 : 24'h00_0000);
        chk({22'h00_0000, pd_pin, em_pin}, (c < 5) ? (s ? 24'h00_0001 : 24'h00_0002) : 24'h00_0000);
      end
    end
    $display("test alarm routing done");
  endtask

  task automatic t_timer();
    logic [23:0] nt, nw, nv, got;
    i_host.write_reg(`PTC_ADDR_CLEAR3_START, 24'h00_0000);
    sample(20, nt, nw, nv);
    chk(nt + nw + nv + count, 24'h00_0000);
    i_host.write_reg(`PTC_ADDR_CLEAR3_START, 24'h00_0001);
    i_host.write_reg(`PTC_ADDR_CLEAR3_END, 24'h00_0002);
    i_host.write_reg(`PTC_ADDR_PERIOD, 24'h00_0003);
    i_host.write_reg(`PTC_ADDR_CONTROL, 24'h00_0100);
    repeat (10) @(posedge sys_clk);
    // 40 cycles hold four whole periods whatever the phase
    sample(40, nt, nw, nv);
    chk(nt, 24'h00_0010);
    chk(nw, 24'h00_0004);
    chk(nv, 24'h00_0014);
    i_host.read_reg(`PTC_ADDR_STATUS, got);
    chk({23'h00_0000, got[16]}, 24'h00_0001);
    i_host.write_reg(`PTC_ADDR_CONTROL, 24'h00_0000);
    sample(20, nt, nw, nv);
    chk(nt + nw + nv + count, 24'h00_0000);
    $display("test timer done");
  endtask

  initial begin
    rst = 1'b1;
    leds = 9'h000;
    mismatches = 0;
    n_compared = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_alarm();
    t_timer();
    conclude();
  end

  // whole run needs about 0.45 ms
  initial begin
    #3_000_000;
    mismatches++;
    conclude();
  end
endmodule

`default_nettype wire

// ### core/ptc_cfg.svh
`ifndef PTC_CFG_SVH
`define PTC_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PTC_ADDR_CLEAR3_START 8'h1b
`define PTC_ADDR_CLEAR3_END 8'h1c
`define PTC_ADDR_PERIOD 8'h1d
`define PTC_ADDR_CONTROL 8'h1e
`define PTC_ADDR_SPARE 8'h1f
`define PTC_ADDR_FACTORY 8'h20
`define PTC_ADDR_STATUS 8'h30

// ----------------------------------------
// field layout
// ----------------------------------------
`define PTC_REG_BITS 24
`define PTC_COUNT_BITS 16
`define PTC_CTRL_EN_BIT 8
`define PTC_CTRL_SEL_LSB 9
`define PTC_CTRL_SEL_MSB 11
`define PTC_STAT_RUN_BIT 16
`define PTC_COUNT_RESET 16'h0000
`define PTC_SEL_RESET 3'h0

// ----------------------------------------
// serial frame
// ----------------------------------------
`define PTC_ADDR_BITS 8
`define PTC_FRAME_BITS 32
`define PTC_READ_BIT 7

// ----------------------------------------
// timing
// ----------------------------------------
`define PTC_SYS_CLK_MHZ 10
`define PTC_TICK_MHZ 4

`endif

// ### core/ptc_pkg.sv
package ptc_pkg;

  // alarm pin routing codes
  typedef enum logic [2:0] {
    PTC_SEL_SAMPLE = 3'h0,
    PTC_SEL_PULSE = 3'h1,
    PTC_SEL_SAMPLE_PULSE = 3'h2,
    PTC_SEL_CONVERT = 3'h3,
    PTC_SEL_AMBIENT = 3'h4,
    PTC_SEL_OFF5 = 3'h5,
    PTC_SEL_OFF6 = 3'h6,
    PTC_SEL_OFF7 = 3'h7
  } ptc_alarm_sel_t;

  typedef logic [15:0] ptc_count_t;
  typedef logic [23:0] ptc_word_t;

endpackage

// ### core/ptc_regs_top.sv
// Contract
// - sixteen-bit start count places the fourth adc clear window start.
// - separate sixteen-bit end count places that window end; zero after reset.
// - repetition period is a sixteen-bit count of 4 MHz cycles.
// - timer enable bit 8 clear keeps timer and clocks stopped; reset clear.
// - timer enable bit set runs the pulse sequence timer.
// - selector bits 11..9 codes 000, 001, 010 route sample and pulse signals.
// - codes 011 convert, 100 ambient, 101 to 111 drive nothing on alarm pins.
// - all start and end counts are 4 MHz cycles from period start.
`timescale 1ns/1ps
`default_nettype none
`include "ptc_cfg.svh"

module ptc_regs_top #(
  parameter int COUNT_W = `PTC_COUNT_BITS,
  parameter int SYS_MHZ = `PTC_SYS_CLK_MHZ,
  parameter int TICK_MHZ = `PTC_TICK_MHZ
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // serial register port
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso_ff,
  // timing signals from the other windows
  input wire logic led2_sample,
  input wire logic led1_sample,
  input wire logic led2_pulse,
  input wire logic led1_pulse,
  input wire logic led1_sample_pulse,
  input wire logic led2_convert,
  input wire logic led1_convert,
  input wire logic led2_ambient,
  input wire logic led1_ambient,
  // alarm pins
  output logic photodiode_alarm_pin_ff,
  output logic photodiode_alarm_oe_ff,
  output logic emitter_alarm_pin_ff,
  output logic emitter_alarm_oe_ff,
  // timebase
  output logic timer_tick_ff,
  output logic period_start_ff,
  output logic [COUNT_W-1:0] timer_count_ff,
  output logic adc_clear3_window_ff
);

  localparam int ACC_W = 8;

  logic [7:0] addr;
  logic [23:0] wdata;
  logic wr_valid;
  logic [23:0] rd_data;

  logic [COUNT_W-1:0] adc_clear3_start_ff;
  logic [COUNT_W-1:0] adc_clear3_end_ff;
  logic [COUNT_W-1:0] repetition_period_value_ff;
  logic timer_module_on_ff;
  ptc_pkg::ptc_alarm_sel_t alarm_pin_signal_select_ff;
  logic [ACC_W-1:0] acc_ff;
  logic [ACC_W-1:0] nxt_acc;
  logic nxt_tick;
  logic nxt_pd_pin;
  logic nxt_em_pin;
  logic nxt_pin_oe;

  // ----------------------------------------
  // serial slave
  // ----------------------------------------
  ptc_spi_slave u_spi (
    .sys_clk(sys_clk),
    .rst(rst),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso_ff(spi_miso_ff),
    .rd_data(rd_data),
    .addr_ff(addr),
    .wdata_ff(wdata),
    .wr_valid_ff(wr_valid)
  );

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // upper bits are dropped; host is expected to send zeros there
  // start count store
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      adc_clear3_start_ff <= COUNT_W'(`PTC_COUNT_RESET);
    end else if (wr_valid && addr == `PTC_ADDR_CLEAR3_START) begin
      adc_clear3_start_ff <= wdata[COUNT_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      adc_clear3_end_ff <= COUNT_W'(`PTC_COUNT_RESET);
    end else if (wr_valid && addr == `PTC_ADDR_CLEAR3_END) begin
      adc_clear3_end_ff <= wdata[COUNT_W-1:0];
    end
  end

  // period count store
  // a period cut below the running count wraps at the next tick
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      repetition_period_value_ff <= COUNT_W'(`PTC_COUNT_RESET);
    end else if (wr_valid && addr == `PTC_ADDR_PERIOD) begin
      repetition_period_value_ff <= wdata[COUNT_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timer_module_on_ff <= 1'b0;
    end else if (wr_valid && addr == `PTC_ADDR_CONTROL) begin
      timer_module_on_ff <= wdata[`PTC_CTRL_EN_BIT];
    end
  end

  // selector capture
  // every code is legal, so the cast never leaves the enum
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alarm_pin_signal_select_ff <= ptc_pkg::PTC_SEL_SAMPLE;
    end else if (wr_valid && addr == `PTC_ADDR_CONTROL) begin
      alarm_pin_signal_select_ff <= ptc_pkg::ptc_alarm_sel_t'(wdata[`PTC_CTRL_SEL_MSB:`PTC_CTRL_SEL_LSB]);
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  // spare and factory registers read as zero
  always_comb begin
    rd_data = 24'h00_0000;
    unique case (addr & 8'h7f)
      `PTC_ADDR_CLEAR3_START: rd_data = 24'(adc_clear3_start_ff);
      `PTC_ADDR_CLEAR3_END: rd_data = 24'(adc_clear3_end_ff);
      `PTC_ADDR_PERIOD: rd_data = 24'(repetition_period_value_ff);
      `PTC_ADDR_CONTROL: begin
        rd_data[`PTC_CTRL_EN_BIT] = timer_module_on_ff;
        rd_data[`PTC_CTRL_SEL_MSB:`PTC_CTRL_SEL_LSB] = alarm_pin_signal_select_ff;
      end
      `PTC_ADDR_STATUS: begin
        rd_data[COUNT_W-1:0] = timer_count_ff;
        rd_data[`PTC_STAT_RUN_BIT] = timer_module_on_ff;
      end
      `PTC_ADDR_SPARE: rd_data = 24'h00_0000;
      `PTC_ADDR_FACTORY: rd_data = 24'h00_0000;
      default: rd_data = 24'h00_0000;
    endcase
  end

  // ----------------------------------------
  // 4 MHz tick from fractional divider
  // ----------------------------------------
  // tick spacing alternates 2 and 3 cycles; average rate is exact
  always_comb begin
    nxt_acc = acc_ff + ACC_W'(TICK_MHZ);
    nxt_tick = 1'b0;
    if (nxt_acc >= ACC_W'(SYS_MHZ)) begin
      nxt_acc = nxt_acc - ACC_W'(SYS_MHZ);
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_ff <= 8'h00;
    end else if (!timer_module_on_ff) begin
      acc_ff <= 8'h00;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timer_tick_ff <= 1'b0;
    end else begin
      timer_tick_ff <= timer_module_on_ff && nxt_tick;
    end
  end

  // ----------------------------------------
  // period counter
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timer_count_ff <= COUNT_W'(`PTC_COUNT_RESET);
      period_start_ff <= 1'b0;
    end else if (!timer_module_on_ff) begin
      timer_count_ff <= COUNT_W'(`PTC_COUNT_RESET);
      period_start_ff <= 1'b0;
    end else begin
      period_start_ff <= 1'b0;
      if (timer_tick_ff) begin
        if (timer_count_ff >= repetition_period_value_ff) begin
          timer_count_ff <= COUNT_W'(`PTC_COUNT_RESET);
          period_start_ff <= 1'b1;
        end else begin
          timer_count_ff <= timer_count_ff + COUNT_W'(1);
        end
      end
    end
  end

  // ----------------------------------------
  // fourth adc clear window
  // ----------------------------------------
  // window trails the count by one cycle, like the alarm pins
  // window from start and end counts
  ptc_window_gen #(
    .W(COUNT_W)
  ) u_clear3 (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(timer_module_on_ff),
    .count(timer_count_ff),
    .start_count(adc_clear3_start_ff),
    .end_count(adc_clear3_end_ff),
    .window_ff(adc_clear3_window_ff)
  );

  // ----------------------------------------
  // alarm pin routing
  // ----------------------------------------
  // one cycle of latency keeps both pins straight from flops
  always_comb begin
    nxt_pd_pin = 1'b0;
    nxt_em_pin = 1'b0;
    nxt_pin_oe = 1'b1;
    unique case (alarm_pin_signal_select_ff)
      ptc_pkg::PTC_SEL_SAMPLE: begin
        nxt_pd_pin = led2_sample;
        nxt_em_pin = led1_sample;
      end
      ptc_pkg::PTC_SEL_PULSE: begin
        nxt_pd_pin = led2_pulse;
        nxt_em_pin = led1_pulse;
      end
      ptc_pkg::PTC_SEL_SAMPLE_PULSE: begin
        nxt_pd_pin = led2_sample;
        nxt_em_pin = led1_sample_pulse;
      end
      ptc_pkg::PTC_SEL_CONVERT: begin
        nxt_pd_pin = led2_convert;
        nxt_em_pin = led1_convert;
      end
      ptc_pkg::PTC_SEL_AMBIENT: begin
        nxt_pd_pin = led2_ambient;
        nxt_em_pin = led1_ambient;
      end
      ptc_pkg::PTC_SEL_OFF5, ptc_pkg::PTC_SEL_OFF6, ptc_pkg::PTC_SEL_OFF7: begin
        nxt_pd_pin = 1'b0;
        nxt_em_pin = 1'b0;
        nxt_pin_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      photodiode_alarm_pin_ff <= 1'b0;
      emitter_alarm_pin_ff <= 1'b0;
    end else begin
      photodiode_alarm_pin_ff <= nxt_pd_pin;
      emitter_alarm_pin_ff <= nxt_em_pin;
    end
  end

  // enables follow the selector
  // a released pin shows low here; the board sets its real level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      photodiode_alarm_oe_ff <= 1'b0;
      emitter_alarm_oe_ff <= 1'b0;
    end else begin
      photodiode_alarm_oe_ff <= nxt_pin_oe;
      emitter_alarm_oe_ff <= nxt_pin_oe;
    end
  end

endmodule
`default_nettype wire

// ### core/ptc_spi_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptc_cfg.svh"

module ptc_spi_slave (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // serial pins, sampled on sys_clk
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso_ff,
  // register side
  input wire logic [23:0] rd_data,
  output logic [7:0] addr_ff,
  output logic [23:0] wdata_ff,
  output logic wr_valid_ff
);

  logic sclk_q_ff;
  logic [5:0] bit_cnt_ff;
  logic [30:0] shift_ff;
  logic [22:0] out_sh_ff;
  logic rise;
  logic fall;
  logic is_read;

  assign rise = spi_sclk & ~sclk_q_ff & ~spi_cs_n;
  assign fall = ~spi_sclk & sclk_q_ff & ~spi_cs_n;
  assign is_read = addr_ff[`PTC_READ_BIT];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclk_q_ff <= 1'b0;
    end else begin
      sclk_q_ff <= spi_sclk;
    end
  end

  // ----------------------------------------
  // receive: mode 0, msb first
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bit_cnt_ff <= 6'h00;
      shift_ff <= 31'h0000_0000;
      addr_ff <= 8'h00;
      wdata_ff <= 24'h00_0000;
      wr_valid_ff <= 1'b0;
    end else begin
      wr_valid_ff <= 1'b0;
      if (spi_cs_n) begin
        // frame aborted or done: restart
        bit_cnt_ff <= 6'h00;
      end else if (rise && bit_cnt_ff < 6'(`PTC_FRAME_BITS)) begin
        shift_ff <= {shift_ff[29:0], spi_mosi};
        bit_cnt_ff <= bit_cnt_ff + 6'h01;
        if (bit_cnt_ff == 6'(`PTC_ADDR_BITS - 1)) begin
          addr_ff <= {shift_ff[6:0], spi_mosi};
        end
        if (bit_cnt_ff == 6'(`PTC_FRAME_BITS - 1) && !is_read) begin
          wdata_ff <= {shift_ff[22:0], spi_mosi};
          wr_valid_ff <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // transmit on falling edges
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_sh_ff <= 23'h00_0000;
      spi_miso_ff <= 1'b0;
    end else if (spi_cs_n) begin
      spi_miso_ff <= 1'b0;
    end else if (fall && is_read) begin
      if (bit_cnt_ff == 6'(`PTC_ADDR_BITS)) begin
        spi_miso_ff <= rd_data[23];
        out_sh_ff <= rd_data[22:0];
      end else if (bit_cnt_ff > 6'(`PTC_ADDR_BITS)) begin
        spi_miso_ff <= out_sh_ff[22];
        out_sh_ff <= {out_sh_ff[21:0], 1'b0};
      end
    end
  end

endmodule
`default_nettype wire

// ### core/ptc_window_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptc_cfg.svh"

module ptc_window_gen #(
  parameter int W = `PTC_COUNT_BITS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // timebase
  input wire logic run,
  input wire logic [W-1:0] count,
  // window edges
  input wire logic [W-1:0] start_count,
  input wire logic [W-1:0] end_count,
  // result
  output logic window_ff
);

  logic nxt_window;

  always_comb begin
    nxt_window = run && (count >= start_count) && (count <= end_count);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      window_ff <= 1'b0;
    end else begin
      window_ff <= nxt_window;
    end
  end

endmodule
`default_nettype wire
